// *** include/digital_top_page_defines.svh ***
`ifndef DIGITAL_TOP_PAGE_DEFINES_SVH
`define DIGITAL_TOP_PAGE_DEFINES_SVH

// Register offsets
`define OFS_TRIM_RATE      8'h64
`define OFS_WORD1_LO       8'h8d
`define OFS_WORD1_HI       8'h8e
`define OFS_WORD2_LO       8'h8f
`define OFS_WORD2_HI       8'h90
`define OFS_PATTERN_CTL    8'h91
`define OFS_SPECIAL_FIRST  8'hab
`define OFS_SPECIAL_SECOND 8'hac
`define OFS_MODE_AB        8'had
`define OFS_MODE_CD        8'hae
`define OFS_TRIM_LOAD      8'hb7

// Field positions
`define POS_CHOICE_MSB     7
`define POS_CHOICE_LSB     4
`define POS_ENABLE_MSB     3
`define POS_ENABLE_LSB     0
`define POS_MODE_MSB       3
`define POS_MODE_LSB       0
`define POS_RATE_BIT       1
`define POS_SPECIAL_BIT    0
`define POS_TRIM_GO_BIT    0

// Reset values
`define RST_BYTE           8'h00
`define RST_WORD           16'h0000

// Fixed pattern words
`define WORD_ZEROS         16'h0000
`define WORD_ONES          16'hffff
`define WORD_DESKEW        16'haaaa

// Serial frame: 16 header bits then 8 data bits
`define FRAME_HDR_BITS     5'd16
`define FRAME_ALL_BITS     5'd24

`endif

// *** include/digital_top_page_pkg.sv ***
package digital_top_page_pkg;

  // Pattern choice codes
  typedef enum logic [3:0] {
    pat_normal  = 4'h0,
    pat_zeros   = 4'h1,
    pat_ones    = 4'h2,
    pat_toggle  = 4'h3,
    pat_ramp    = 4'h4,
    pat_user1   = 4'h6,
    pat_user12  = 4'h7,
    pat_deskew  = 4'h8
  } pattern_code_t;

  // Register access request from the serial port
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // Down-conversion selection handed to a channel pair
  typedef struct packed {
    logic [3:0] sel;
    logic       ok;
  } mode_out_t;

endpackage

// *** core/serial_reg_port.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "digital_top_page_defines.svh"

module serial_reg_port
  import digital_top_page_pkg::*;
(
  input  wire logic       clock,    // System clock
  input  wire logic       sys_rst,  // Synchronous reset
  input  wire logic       sclk,     // Serial clock, sampled
  input  wire logic       sen_n,    // Serial enable, active low
  input  wire logic       sdin,     // Serial data in
  output logic            sdout,    // Serial data out
  output reg_req_t        req,      // Register request, one-cycle strobes
  input  wire logic [7:0] rdata     // Read data for req.addr
);

  logic       sclk_q;
  logic [4:0] count;
  logic [15:0] shin;
  logic [7:0] shout;
  logic       is_read;

  // Edge detection of the sampled serial clock
  wire sclk_rise = sclk & ~sclk_q & ~sen_n;
  wire sclk_fall = ~sclk & sclk_q & ~sen_n;
  wire [15:0] shin_next = {shin[14:0], sdin};
  wire [4:0]  count_next = count + 5'd1;
  wire hdr_done = sclk_rise & (count_next == `FRAME_HDR_BITS);
  wire all_done = sclk_rise & (count_next == `FRAME_ALL_BITS);
  wire in_data  = count >= `FRAME_HDR_BITS;
  // Address parks in the upper byte while the data byte shifts in below
  wire [15:0] shin_load = hdr_done ? {shin_next[7:0], 8'h00}
                        : in_data  ? {shin[15:8], shin_next[7:0]}
                        : shin_next;

  // Requests: read after the header, write after the data byte
  assign req.rd    = hdr_done & shin_next[15];
  assign req.wr    = all_done & ~is_read;
  assign req.addr  = hdr_done ? shin_next[7:0] : shin[15:8];
  assign req.wdata = shin_next[7:0];
  assign sdout     = shout[7];

  // Frame shifter
  always_ff @(posedge clock) begin
    sclk_q <= sclk;
    if (sys_rst || sen_n) begin
      count   <= 5'd0;
      shin    <= `RST_WORD;
      shout   <= `RST_BYTE;
      is_read <= 1'b0;
    end else begin
      if (sclk_rise) begin
        count <= count_next;
        shin  <= shin_load;
      end
      if (hdr_done) begin
        is_read <= shin_next[15];
        shout   <= req.rd ? rdata : `RST_BYTE;
      end else if (sclk_fall && count > `FRAME_HDR_BITS) begin
        shout <= {shout[6:0], 1'b0};
      end
    end
  end

endmodule
`default_nettype wire

// *** core/digital_top_page.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "digital_top_page_defines.svh"

module digital_top_page
  import digital_top_page_pkg::*;
#(
  parameter int CHANNELS = 4,
  parameter int WIDTH    = 16
) (
  input  wire logic                       clock,      // 125 MHz clock
  input  wire logic                       sys_rst,    // Synchronous reset
  input  wire logic                       sclk,       // Serial clock
  input  wire logic                       sen_n,      // Serial enable
  input  wire logic                       sdin,       // Serial data in
  output logic                            sdout,      // Serial data out
  input  wire logic [CHANNELS*WIDTH-1:0]  chan_in,    // Normal data A..D
  output logic [CHANNELS*WIDTH-1:0]       chan_out,   // Output data A..D
  output mode_out_t                       mode_ab,    // Pair AB mode
  output mode_out_t                       mode_cd,    // Pair CD mode
  output logic                            special_ok, // Both special bits set
  output logic                            trim_start, // Trim load pulse
  output logic                            trim_rate   // 1: 500, 0: 375 MSPS
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  reg_req_t   req;
  logic [7:0] rdata;
  logic [3:0] pattern_choice;
  logic [3:0] pattern_enable;
  logic [15:0] user_word_first;
  logic [15:0] user_word_second;
  logic       mandatory_cfg_bit_first;
  logic       mandatory_cfg_bit_second;
  logic [3:0] downconv_sel_pair_ab;
  logic [3:0] downconv_sel_pair_cd;
  logic       trim_load_go;
  logic       trim_load_go_q;
  logic       trim_rate_pick;
  logic       toggle_phase;
  logic [WIDTH-1:0] ramp;

  serial_reg_port u_port (
    .clock   (clock),
    .sys_rst (sys_rst),
    .sclk    (sclk),
    .sen_n   (sen_n),
    .sdin    (sdin),
    .sdout   (sdout),
    .req     (req),
    .rdata   (rdata)
  );

  // Address decode of writes
  wire wr_pat  = req.wr && req.addr == `OFS_PATTERN_CTL;
  wire wr_w1lo = req.wr && req.addr == `OFS_WORD1_LO;
  wire wr_w1hi = req.wr && req.addr == `OFS_WORD1_HI;
  wire wr_w2lo = req.wr && req.addr == `OFS_WORD2_LO;
  wire wr_w2hi = req.wr && req.addr == `OFS_WORD2_HI;
  wire wr_sp1  = req.wr && req.addr == `OFS_SPECIAL_FIRST;
  wire wr_sp2  = req.wr && req.addr == `OFS_SPECIAL_SECOND;
  wire wr_ab   = req.wr && req.addr == `OFS_MODE_AB;
  wire wr_cd   = req.wr && req.addr == `OFS_MODE_CD;
  wire wr_trim = req.wr && req.addr == `OFS_TRIM_LOAD;
  wire wr_rate = req.wr && req.addr == `OFS_TRIM_RATE;

  // Register storage; only defined bits are kept
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pattern_choice           <= 4'h0;
      pattern_enable           <= 4'h0;
      user_word_first          <= `RST_WORD;
      user_word_second         <= `RST_WORD;
      mandatory_cfg_bit_first  <= 1'b0;
      mandatory_cfg_bit_second <= 1'b0;
      downconv_sel_pair_ab     <= 4'h0;
      downconv_sel_pair_cd     <= 4'h0;
      trim_load_go             <= 1'b0;
      trim_rate_pick           <= 1'b0;
    end else begin
      if (wr_pat) begin
        pattern_choice <= req.wdata[`POS_CHOICE_MSB:`POS_CHOICE_LSB];
        pattern_enable <= req.wdata[`POS_ENABLE_MSB:`POS_ENABLE_LSB];
      end
      if (wr_w1lo) user_word_first[7:0]   <= req.wdata;
      if (wr_w1hi) user_word_first[15:8]  <= req.wdata;
      if (wr_w2lo) user_word_second[7:0]  <= req.wdata;
      if (wr_w2hi) user_word_second[15:8] <= req.wdata;
      if (wr_sp1) mandatory_cfg_bit_first <= req.wdata[`POS_SPECIAL_BIT];
      if (wr_sp2) mandatory_cfg_bit_second <= req.wdata[`POS_SPECIAL_BIT];
      if (wr_ab) downconv_sel_pair_ab <= req.wdata[3:0];
      if (wr_cd) downconv_sel_pair_cd <= req.wdata[3:0];
      if (wr_trim) trim_load_go <= req.wdata[`POS_TRIM_GO_BIT];
      if (wr_rate) trim_rate_pick <= req.wdata[`POS_RATE_BIT];
    end
  end

  // Read mux; unused bits and unmapped offsets read zero
  always_comb begin
    unique case (req.addr)
      `OFS_PATTERN_CTL:    rdata = {pattern_choice, pattern_enable};
      `OFS_WORD1_LO:       rdata = user_word_first[7:0];
      `OFS_WORD1_HI:       rdata = user_word_first[15:8];
      `OFS_WORD2_LO:       rdata = user_word_second[7:0];
      `OFS_WORD2_HI:       rdata = user_word_second[15:8];
      `OFS_SPECIAL_FIRST:  rdata = {7'h00, mandatory_cfg_bit_first};
      `OFS_SPECIAL_SECOND: rdata = {7'h00, mandatory_cfg_bit_second};
      `OFS_MODE_AB:        rdata = {4'h0, downconv_sel_pair_ab};
      `OFS_MODE_CD:        rdata = {4'h0, downconv_sel_pair_cd};
      `OFS_TRIM_LOAD:      rdata = {7'h00, trim_load_go};
      `OFS_TRIM_RATE:      rdata = {6'h00, trim_rate_pick, 1'b0};
      default:             rdata = `RST_BYTE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode outputs and trim load

  function automatic logic mode_listed(input logic [3:0] m);
    mode_listed = (m <= 4'h4) || (m == 4'h6) || (m == 4'h7) || (m == 4'h8);
  endfunction

  // Mode fields steer the pairs; unlisted codes are flagged
  assign mode_ab.sel = downconv_sel_pair_ab;
  assign mode_ab.ok  = mode_listed(downconv_sel_pair_ab);
  assign mode_cd.sel = downconv_sel_pair_cd;
  assign mode_cd.ok  = mode_listed(downconv_sel_pair_cd);
  assign special_ok  = mandatory_cfg_bit_first & mandatory_cfg_bit_second;
  assign trim_rate   = trim_rate_pick;

  // Trim load starts on the rising transition of the level
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      trim_load_go_q <= 1'b0;
      trim_start     <= 1'b0;
    end else begin
      trim_load_go_q <= trim_load_go;
      trim_start     <= trim_load_go & ~trim_load_go_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pattern generator

  // Toggle phase and ramp run freely while any pattern may be shown
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      toggle_phase <= 1'b0;
      ramp         <= '0;
    end else begin
      toggle_phase <= ~toggle_phase;
      ramp         <= ramp + 1'b1;
    end
  end

  logic [WIDTH-1:0] pattern_word;
  logic             pattern_known;

  // Pattern word selection from the choice field
  always_comb begin
    pattern_known = 1'b1;
    unique case (pattern_choice)
      pat_zeros:  pattern_word = `WORD_ZEROS;
      pat_ones:   pattern_word = `WORD_ONES;
      pat_toggle: pattern_word = toggle_phase ? `WORD_ONES : `WORD_ZEROS;
      pat_ramp:   pattern_word = ramp;
      pat_user1:  pattern_word = user_word_first;
      pat_user12: pattern_word = toggle_phase ? user_word_second
                                              : user_word_first;
      pat_deskew: pattern_word = `WORD_DESKEW;
      default: begin
        pattern_word  = `WORD_ZEROS;
        pattern_known = 1'b0;
      end
    endcase
  end

  // Per-channel output selection
  for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
    wire use_pat = pattern_enable[c] & pattern_known;
    always_ff @(posedge clock) begin
      if (sys_rst) begin
        chan_out[c*WIDTH +: WIDTH] <= '0;
      end else begin
        chan_out[c*WIDTH +: WIDTH] <= use_pat ? pattern_word
                                              : chan_in[c*WIDTH +: WIDTH];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  wire [WIDTH-1:0] out_a = chan_out[WIDTH-1:0];
  wire [WIDTH-1:0] in_a  = chan_in[WIDTH-1:0];
  wire             pat_a = pattern_enable[0];

  sequence s_rise_trim;
    !trim_load_go ##1 trim_load_go;
  endsequence

  property p_reset_clear;
    @(posedge clock) sys_rst |=> pattern_enable == 4'h0 && !trim_start
      && downconv_sel_pair_ab == 4'h0 && downconv_sel_pair_cd == 4'h0;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("fields not cleared by reset");

  property p_fixed_words;
    @(posedge clock) disable iff (sys_rst)
      pat_a && pattern_choice == pat_ones |=> out_a == `WORD_ONES;
  endproperty
  a_fixed_words: assert property (p_fixed_words)
    else $error("ones pattern missing on channel A");

  property p_user_first;
    @(posedge clock) disable iff (sys_rst)
      pat_a && pattern_choice == pat_user1 |=> out_a == $past(user_word_first);
  endproperty
  a_user_first: assert property (p_user_first)
    else $error("user word one missing on channel A");

  property p_user_alt;
    @(posedge clock) disable iff (sys_rst)
      pat_a && pattern_choice == pat_user12 ##1
      pat_a && pattern_choice == pat_user12 |=> out_a != $past(out_a)
        || user_word_first == user_word_second;
  endproperty
  a_user_alt: assert property (p_user_alt)
    else $error("user words not alternating");

  property p_deskew;
    @(posedge clock) disable iff (sys_rst)
      pat_a && pattern_choice == pat_deskew |=> out_a == `WORD_DESKEW;
  endproperty
  a_deskew: assert property (p_deskew)
    else $error("deskew word missing on channel A");

  property p_normal_pass;
    @(posedge clock) disable iff (sys_rst)
      !sys_rst && (!pat_a || pattern_choice == 4'h5) |=> out_a == $past(in_a);
  endproperty
  a_normal_pass: assert property (p_normal_pass)
    else $error("channel A not carrying normal data");

  property p_mode_flag;
    @(posedge clock) disable iff (sys_rst)
      wr_ab && req.wdata[3:0] == 4'h5 |=> !mode_ab.ok && mode_ab.sel == 4'h5;
  endproperty
  a_mode_flag: assert property (p_mode_flag)
    else $error("pair AB mode flag wrong");

  property p_mode_cd;
    @(posedge clock) disable iff (sys_rst)
      wr_cd && !wr_ab |=> mode_cd.sel == $past(req.wdata[3:0])
        && $stable(mode_ab.sel);
  endproperty
  a_mode_cd: assert property (p_mode_cd)
    else $error("pair CD mode not independent");

  property p_trim_pulse;
    @(posedge clock) disable iff (sys_rst)
      s_rise_trim |=> trim_start ##1 !trim_start;
  endproperty
  a_trim_pulse: assert property (p_trim_pulse)
    else $error("trim load not a single pulse");

  property p_word_build;
    @(posedge clock) disable iff (sys_rst)
      wr_w1hi |=> user_word_first[15:8] == $past(req.wdata);
  endproperty
  a_word_build: assert property (p_word_build)
    else $error("user word high byte not stored");

  property p_rate;
    @(posedge clock) disable iff (sys_rst)
      wr_rate |=> trim_rate == $past(req.wdata[`POS_RATE_BIT]);
  endproperty
  a_rate: assert property (p_rate)
    else $error("trim rate not following write");

endmodule
`default_nettype wire

// *** verification/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "digital_top_page_defines.svh"

module tb
  import digital_top_page_pkg::*;
;
  ////////////////////////////////////////////////////////////////////////////
  localparam logic [15:0] W1 = 16'h1234;
  localparam logic [15:0] W2 = 16'habcd;
  localparam logic [7:0]  OFS_LIST [11] = '{`OFS_TRIM_RATE, `OFS_WORD1_LO,
    `OFS_WORD1_HI, `OFS_WORD2_LO, `OFS_WORD2_HI, `OFS_PATTERN_CTL,
    `OFS_SPECIAL_FIRST, `OFS_SPECIAL_SECOND, `OFS_MODE_AB, `OFS_MODE_CD,
    `OFS_TRIM_LOAD};

  logic        clock;
  logic        sys_rst;
  logic        sclk;
  logic        sen_n;
  logic        sdin;
  logic        sdout;
  logic [63:0] chan_in;
  logic [63:0] chan_out;
  mode_out_t   mode_ab;
  mode_out_t   mode_cd;
  logic        special_ok;
  logic        trim_start;
  logic        trim_rate;
  logic [7:0]  q;
  int          miscompares;
  int          n_checks;
  int          pulses;

  digital_top_page #(.CHANNELS(4), .WIDTH(16)) dut (
    .clock(clock), .sys_rst(sys_rst), .sclk(sclk), .sen_n(sen_n),
    .sdin(sdin), .sdout(sdout), .chan_in(chan_in), .chan_out(chan_out),
    .mode_ab(mode_ab), .mode_cd(mode_cd), .special_ok(special_ok),
    .trim_start(trim_start), .trim_rate(trim_rate));

  // Free-running clock, 8 ns period
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // Count cycles in which the trim pulse is high
  always @(posedge clock) begin
    if (trim_start === 1'b1) pulses <= pulses + 1;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic chk_reg(input string nm, input logic [7:0] e,
                         input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_word(input string nm, input logic [15:0] e,
                          input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask

  // One 24-bit serial frame, MSB first; read data sampled in high phases
  task automatic xfer(input logic rd, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] r);
    logic [23:0] f;
    f = {rd, 7'h00, a, d};
    r = 8'h00;
    @(posedge clock);
    sen_n <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      @(posedge clock);
      sclk <= 1'b0;
      sdin <= f[i];
      tick(2);
      sclk <= 1'b1;
      tick(3);
      #1;
      if (i <= 7) r[i] = sdout;
    end
    @(posedge clock);
    sclk <= 1'b0;
    tick(2);
    sen_n <= 1'b1;
    sdin  <= 1'b0;
    tick(3);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b0, a, d, q);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [7:0] e);
    xfer(1'b1, a, 8'h00, q);
    chk_reg(nm, e, q);
  endtask

  // Select a pattern, then compare two successive output words per channel
  task automatic chk_pat(input logic [3:0] code, input logic [3:0] en);
    logic [63:0] s0, s1;
    logic [15:0] v0, v1, e;
    logic        dyn;
    wr(`OFS_PATTERN_CTL, {code, en});
    @(posedge clock);
    #1 s0 = chan_out;
    @(posedge clock);
    #1 s1 = chan_out;
    for (int c = 0; c < 4; c++) begin
      v0  = s0[c*16 +: 16];
      v1  = s1[c*16 +: 16];
      dyn = en[c] && (code == 4'h3 || code == 4'h4 || code == 4'h7);
      case (en[c] ? code : 4'h0)
        4'h1: e = `WORD_ZEROS;
        4'h2: e = `WORD_ONES;
        4'h3: begin
          chk_bit("toggle level", 1'b1,
                  v0 === `WORD_ZEROS || v0 === `WORD_ONES);
          e = ~v0;
        end
        4'h4: e = v0 + 16'h0001;
        4'h6: e = W1;
        4'h7: begin
          chk_bit("alternate level", 1'b1,
                  v0 === W1 || v0 === W2);
          e = (v0 === W1) ? W2 : W1;
        end
        4'h8: e = `WORD_DESKEW;
        default: e = chan_in[c*16 +: 16];
      endcase
      if (!dyn) chk_word("pattern first", e, v0);
      chk_word("pattern next", e, v1);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    sclk    = 1'b0;
    sen_n   = 1'b1;
    sdin    = 1'b0;
    chan_in = 64'h4444_3333_2222_1111;
    tick(5);
    sys_rst <= 1'b0;
    foreach (OFS_LIST[k]) begin
      rd_chk("reset value", OFS_LIST[k], 8'h00);
    end
    chk_bit("mode ab ok", 1'b1, mode_ab.ok);
    chk_word("mode ab sel", 16'h0, {12'h0, mode_ab.sel});
    chk_bit("trim rate", 1'b0, trim_rate);
    @(posedge clock);
    chan_in <= 64'h8888_7777_6666_5555;
    @(posedge clock);
    #1 chk_word("normal data d", 16'h8888, chan_out[63:48]);
    // Mandatory bits, written with the unused bits kept zero
    wr(`OFS_SPECIAL_FIRST, 8'h01);
    chk_bit("special half", 1'b0, special_ok);
    wr(`OFS_SPECIAL_SECOND, 8'h01);
    rd_chk("special first", `OFS_SPECIAL_FIRST, 8'h01);
    rd_chk("special second", `OFS_SPECIAL_SECOND, 8'h01);
    chk_bit("special ok", 1'b1, special_ok);
    wr(8'h50, 8'h5a);
    rd_chk("unmapped", 8'h50, 8'h00);
    // Every mode code on both pairs, the two pairs set differently
    for (int m = 0; m < 16; m++) begin
      wr(`OFS_MODE_AB, {4'h0, 4'(m)});
      wr(`OFS_MODE_CD, {4'h0, 4'(15 - m)});
      chk_word("mode ab sel", 16'(m), {12'h0, mode_ab.sel});
      chk_bit("mode ab ok", m <= 4 || (m >= 6 && m <= 8),
              mode_ab.ok);
      chk_word("mode cd sel", 16'(15 - m), {12'h0, mode_cd.sel});
      chk_bit("mode cd ok", m >= 11 || (m >= 7 && m <= 9),
              mode_cd.ok);
    end
    wr(`OFS_MODE_AB, 8'h08);
    rd_chk("mode ab reg", `OFS_MODE_AB, 8'h08);
    // User words, then all pattern codes with varied enables
    wr(`OFS_WORD1_LO, W1[7:0]);
    wr(`OFS_WORD1_HI, W1[15:8]);
    wr(`OFS_WORD2_LO, W2[7:0]);
    wr(`OFS_WORD2_HI, W2[15:8]);
    rd_chk("word one high", `OFS_WORD1_HI, W1[15:8]);
    rd_chk("word two low", `OFS_WORD2_LO, W2[7:0]);
    for (int p = 0; p < 10; p++) begin
      chk_pat(4'(p), p[0] ? 4'b0101 : 4'b1010);
    end
    chk_pat(4'hf, 4'hf);
    chk_pat(4'h7, 4'hf);
    rd_chk("pattern reg", `OFS_PATTERN_CTL, 8'h7f);
    // Trim rate and trim load on rising level only
    wr(`OFS_TRIM_RATE, 8'h02);
    rd_chk("trim rate reg", `OFS_TRIM_RATE, 8'h02);
    chk_bit("trim rate high", 1'b1, trim_rate);
    wr(`OFS_TRIM_RATE, 8'h00);
    chk_bit("trim rate low", 1'b0, trim_rate);
    wr(`OFS_TRIM_LOAD, 8'h01);
    chk_word("trim pulses", 16'd1, 16'(pulses));
    wr(`OFS_TRIM_LOAD, 8'h01);
    chk_word("trim pulses", 16'd1, 16'(pulses));
    wr(`OFS_TRIM_LOAD, 8'h00);
    wr(`OFS_TRIM_LOAD, 8'h01);
    chk_word("trim pulses", 16'd2, 16'(pulses));
    // Reset in mid-run clears everything again
    @(posedge clock);
    sys_rst <= 1'b1;
    tick(2);
    sys_rst <= 1'b0;
    rd_chk("after reset", `OFS_PATTERN_CTL, 8'h00);
    rd_chk("after reset", `OFS_TRIM_LOAD, 8'h00);
    rd_chk("after reset", `OFS_WORD2_HI, 8'h00);
    chk_word("mode ab sel", 16'h0, {12'h0, mode_ab.sel});
    chk_bit("special ok", 1'b0, special_ok);
    chk_word("trim pulses", 16'd2, 16'(pulses));
    summarize;
  end

  // Watchdog against a hung frame
  initial begin
    tick(40000);
    miscompares++;
    $display("mismatch watchdog expected finish seen timeout");
    summarize;
  end

endmodule
`default_nettype wire
